/* logic/tws_pkg.sv */
// constants, types and state encoding of the two-wire register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package tws_pkg;

  // ------------------------------------------------------------
  // addresses and byte kinds
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_BYTE_LO = 8'hc0;
  localparam logic [7:0] ADDR_BYTE_HI = 8'hc2;
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_PTR = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } tws_state_t;

  // register write event toward the tuner core
  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } tws_wr_t;

  // three-stage synchroniser plus filtered level
  typedef struct packed {
    logic [2:0] ff;
    logic level;
  } tws_sync_t;

endpackage : tws_pkg

/* logic/tws_slave.sv */
// two-wire register slave with internal byte register file
`timescale 1ns/1ps
module tws_slave #(
  parameter int NUM_REGS = 32
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // address select strap
  input wire logic i_addr_sel,
  // core side
  output tws_pkg::tws_wr_t o_wr,
  output logic o_active
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (NUM_REGS < 1 || NUM_REGS > 256) begin : g_bad_size
    $error("NUM_REGS must be 1 to 256");
  end

  // the address pair may differ only in the strap bit
  if ((tws_pkg::ADDR_BYTE_LO ^ tws_pkg::ADDR_BYTE_HI) != 8'h02) begin : g_bad_addr
    $error("address pair must differ in bit 1 only");
  end

  // limits: no clock stretching and no general call; the pointer wraps at 256,
  // and bytes written past the file are acknowledged but not kept

  // ------------------------------------------------------------
  // state layout
  // ------------------------------------------------------------
  typedef struct packed {
    // filtered pins
    tws_pkg::tws_sync_t scl;
    tws_pkg::tws_sync_t sda;
    tws_pkg::tws_sync_t sel;
    // transfer progress
    tws_pkg::tws_state_t state;
    logic [1:0] kind;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic ack_ok;
    // bus drive and core view
    logic sda_oe;
    logic active;
    tws_pkg::tws_wr_t wr;
    // register file
    logic [NUM_REGS-1:0][7:0] regs;
  } tws_core_t;

  // present and next state
  tws_core_t r;
  tws_core_t next_r;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one synchroniser step: level moves when stages two and three agree
  // so a one-cycle glitch on a pin never reaches the level
  function automatic tws_pkg::tws_sync_t sync_step(input tws_pkg::tws_sync_t s, input logic pin);
    tws_pkg::tws_sync_t n;
    n = s;
    n.ff = {s.ff[1:0], pin};
    if (s.ff[1] == s.ff[2]) begin
      n.level = s.ff[2];
    end
    return n;
  endfunction : sync_step

  // register read; pointers past the file read as zero
  function automatic logic [7:0] reg_read(input logic [NUM_REGS-1:0][7:0] regs, input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (int'(p) < NUM_REGS) begin
      v = regs[p];
    end
    return v;
  endfunction : reg_read

  // load the addressed register for sending; its msb goes out at once
  function automatic tws_core_t load_read(input tws_core_t s);
    tws_core_t n;
    logic [7:0] v;
    n = s;
    v = reg_read(s.regs, s.ptr);
    n.shift = {v[6:0], 1'b0};
    n.sda_oe = ~v[7];
    n.ptr = s.ptr + 8'h01;
    n.cnt = 4'h1;
    n.state = tws_pkg::ST_TX;
    return n;
  endfunction : load_read

  // ------------------------------------------------------------
  // decoded line events
  // ------------------------------------------------------------
  logic scl_now;
  logic sda_now;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] own_addr;
  logic addr_match;

  // edges of the filtered lines, seen one cycle ahead of the level update;
  // looking ahead lets a start win over a data sample at the same edge
  always_comb begin
    // level as it will stand after this edge
    scl_now = (r.scl.ff[1] == r.scl.ff[2]) ? r.scl.ff[2] : r.scl.level;
    sda_now = (r.sda.ff[1] == r.sda.ff[2]) ? r.sda.ff[2] : r.sda.level;

    // clock edges
    scl_rise = scl_now & ~r.scl.level;
    scl_fall = ~scl_now & r.scl.level;

    // data moving while the clock stays high is a control condition
    start_cond = r.scl.level & scl_now & r.sda.level & ~sda_now;
    stop_cond = r.scl.level & scl_now & ~r.sda.level & sda_now;

    // own address from the strap
    own_addr = r.sel.level ? tws_pkg::ADDR_BYTE_HI : tws_pkg::ADDR_BYTE_LO;
    addr_match = (r.shift[7:1] == own_addr[7:1]);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    // pins through three stages
    next_r.scl = sync_step(r.scl, i_scl);
    next_r.sda = sync_step(r.sda, i_sda);
    next_r.sel = sync_step(r.sel, i_addr_sel);
    // store strobe lasts one cycle
    next_r.wr.stb = 1'b0;

    if (start_cond) begin
      // drop any partial byte and wait for an address
      next_r.state = tws_pkg::ST_RX;
      next_r.kind = tws_pkg::KIND_ADDR;
      next_r.cnt = 4'h0;
      next_r.sda_oe = 1'b0;
      next_r.active = 1'b0;
    end else if (stop_cond) begin
      // bus free again; pointer and register file carried over to the next transfer
      next_r.state = tws_pkg::ST_IDLE;
      next_r.cnt = 4'h0;
      next_r.sda_oe = 1'b0;
      next_r.active = 1'b0;
    end else begin
      case (r.state)
        tws_pkg::ST_IDLE: begin
          // line released while waiting for start
          next_r.sda_oe = 1'b0;
        end

        tws_pkg::ST_RX: begin
          if (scl_rise && r.cnt < tws_pkg::BITS_PER_BYTE) begin
            // sample on rising clock, msb first
            next_r.shift = {r.shift[6:0], sda_now};
            next_r.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == tws_pkg::BITS_PER_BYTE) begin
            // eighth bit done: decide on the byte while the clock is low
            next_r.cnt = 4'h0;
            case (r.kind)
              tws_pkg::KIND_ADDR: begin
                if (addr_match) begin
                  next_r.rw = r.shift[0];
                  next_r.sda_oe = 1'b1;
                  next_r.state = tws_pkg::ST_ACK;
                  next_r.active = 1'b1;
                end else begin
                  // not ours: stay off the line until next start
                  next_r.state = tws_pkg::ST_IDLE;
                end
              end
              tws_pkg::KIND_PTR: begin
                // pointer byte: load and acknowledge
                next_r.ptr = r.shift;
                next_r.sda_oe = 1'b1;
                next_r.state = tws_pkg::ST_ACK;
              end
              default: begin
                // store, report, advance pointer, then acknowledge
                if (int'(r.ptr) < NUM_REGS) begin
                  next_r.regs[r.ptr] = r.shift;
                end
                next_r.wr.stb = 1'b1;
                next_r.wr.addr = r.ptr;
                next_r.wr.data = r.shift;
                next_r.ptr = r.ptr + 8'h01;
                next_r.sda_oe = 1'b1;
                next_r.state = tws_pkg::ST_ACK;
              end
            endcase
          end
        end

        tws_pkg::ST_ACK: begin
          // hold low through the ninth high phase, leave at its falling edge
          if (scl_fall) begin
            if (r.kind == tws_pkg::KIND_ADDR && r.rw) begin
              // first read byte goes out straight after the address ack
              next_r = load_read(next_r);
            end else begin
              // back to receiving: pointer byte first, then data
              next_r.sda_oe = 1'b0;
              next_r.cnt = 4'h0;
              next_r.state = tws_pkg::ST_RX;
              next_r.kind = (r.kind == tws_pkg::KIND_ADDR) ? tws_pkg::KIND_PTR : tws_pkg::KIND_DATA;
            end
          end
        end

        tws_pkg::ST_TX: begin
          if (scl_fall) begin
            if (r.cnt == tws_pkg::BITS_PER_BYTE) begin
              // release for the master's acknowledge slot
              next_r.sda_oe = 1'b0;
              next_r.state = tws_pkg::ST_MACK;
            end else begin
              // next bit while the clock is low
              next_r.sda_oe = ~r.shift[7];
              next_r.shift = {r.shift[6:0], 1'b0};
              next_r.cnt = r.cnt + 4'h1;
            end
          end
        end

        tws_pkg::ST_MACK: begin
          if (scl_rise) begin
            // master's answer taken on the rising clock
            next_r.ack_ok = ~sda_now;
          end else if (scl_fall) begin
            if (r.ack_ok) begin
              // master asked for the next register
              next_r = load_read(next_r);
            end else begin
              // stream over; wait for stop or repeated start
              next_r.sda_oe = 1'b0;
              next_r.state = tws_pkg::ST_IDLE;
            end
          end
        end

        default: begin
          // illegal code: recover to idle with the line released
          next_r.state = tws_pkg::ST_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end

    // reset last so it overrides every path; pins read as an idle bus
    if (i_rst) begin
      next_r.scl = '{ff: 3'h7, level: 1'b1};
      next_r.sda = '{ff: 3'h7, level: 1'b1};
      next_r.sel = '{ff: 3'h0, level: 1'b0};
      next_r.state = tws_pkg::ST_IDLE;
      next_r.kind = tws_pkg::KIND_ADDR;
      next_r.cnt = 4'h0;
      next_r.shift = 8'h00;
      next_r.ptr = tws_pkg::PTR_RESET;
      next_r.rw = 1'b0;
      next_r.ack_ok = 1'b0;
      next_r.sda_oe = 1'b0;
      next_r.active = 1'b0;
      next_r.wr = '{stb: 1'b0, addr: 8'h00, data: 8'h00};
      next_r.regs = {NUM_REGS{tws_pkg::REG_RESET}};
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    r <= next_r;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // open-drain: output level is always low, only the enable moves
  always_comb begin
    o_sda = 1'b0;
  end

  // registered outputs toward the pin and the core
  assign o_sda_oe = r.sda_oe;
  assign o_wr = r.wr;
  assign o_active = r.active;

endmodule : tws_slave

/* tb/tws_master_model.sv */
// behavioural two-wire bus master, open drain, 400 khz
`timescale 1ns/1ps
module tws_master_model #(
  parameter int T_Q = 625
) (
  // bus pins
  output logic o_scl,
  output logic o_sda_pull,
  input wire logic i_sda
);
  // bus idles high, clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // one clock: data set mid low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    #(T_Q) o_sda_pull = ~b;
    #(T_Q) o_scl = 1'b1;
    #(T_Q) r = i_sda;
    #(T_Q) o_scl = 1'b0;
  endtask : bit_io
  // start, also repeated start from clock low
  task automatic start_cond();
    #(T_Q) o_sda_pull = 1'b0;
    #(T_Q) o_scl = 1'b1;
    #(T_Q) o_sda_pull = 1'b1;
    #(T_Q) o_scl = 1'b0;
  endtask : start_cond
  // stop, bus left released
  task automatic stop_cond();
    #(T_Q) o_sda_pull = 1'b1;
    #(T_Q) o_scl = 1'b1;
    #(T_Q) o_sda_pull = 1'b0;
    #(T_Q);
  endtask : stop_cond
  // n bits msb first, ack clock only for whole bytes
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    logic r;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(b[i], r);
    end
    ack = 1'b1;
    if (n == 8) begin
      bit_io(1'b1, ack);
    end
  endtask : send
  // receive a byte, then ack or not-ack
  task automatic recv(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~mack, r);
  endtask : recv
endmodule : tws_master_model

/* tb/tws_slave_monitor.sv */
// concurrent port checks for the two-wire register slave
`timescale 1ns/1ps
module tws_slave_monitor #(
  parameter int NUM_REGS = 32
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  // address select strap
  input wire logic i_addr_sel,
  // core side
  input wire tws_pkg::tws_wr_t o_wr,
  input wire logic o_active
);
  // ------------------------------------------------------------
  // bus and core side properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  property p_release; o_sda_oe |-> !o_sda && o_active; endproperty
  a_release: assert property (p_release) else $error("data pin driven high or outside a transfer");
  property p_oe_move; $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2); endproperty
  a_oe_move: assert property (p_oe_move) else $error("data drive moved in clock high");
  property p_ack_hold; $rose(o_sda_oe) |-> o_sda_oe[*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low drive too short");
  property p_stb_once; o_wr.stb |=> !o_wr.stb; endproperty
  a_stb_once: assert property (p_stb_once) else $error("store pulse too long");
  property p_stb_ack; o_wr.stb |-> o_active ##[0:3] o_sda_oe; endproperty
  a_stb_ack: assert property (p_stb_ack) else $error("store without ack");
  property p_start; i_scl && $past(i_scl) && $fell(i_sda) |-> ##[1:6] !o_active; endproperty
  a_start: assert property (p_start) else $error("start not seen");
  property p_stop; i_scl && $past(i_scl) && $rose(i_sda) |-> ##[1:6] !o_active[*8]; endproperty
  a_stop: assert property (p_stop) else $error("stop not seen");
  property p_act_ack; $rose(o_active) |-> ##[0:120] o_sda_oe; endproperty
  a_act_ack: assert property (p_act_ack) else $error("address taken without ack");
endmodule : tws_slave_monitor

bind tws_slave tws_slave_monitor #(.NUM_REGS(NUM_REGS)) u_mon (.i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel), .o_wr(o_wr), .o_active(o_active));

/* tb/tws_slave_tb.sv */
// self-checking bench for the two-wire register slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tws_slave_tb;
  logic i_clock;
  logic i_rst;
  logic i_addr_sel;
  logic scl;
  logic pull;
  logic o_sda;
  logic o_sda_oe;
  logic o_active;
  tws_pkg::tws_wr_t o_wr;
  logic [7:0] wr_a[$];
  logic [7:0] wr_d[$];
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  wire sda = (o_sda_oe ? o_sda : 1'b1) & ~pull;
  tws_slave #(.NUM_REGS(32)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel), .o_wr(o_wr), .o_active(o_active));
  tws_master_model m (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));
  // clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // collect store pulses, timeout
  always @(negedge i_clock) begin
    cyc++;
    if (o_wr.stb === 1'b1) begin
      wr_a.push_back(o_wr.addr);
      wr_d.push_back(o_wr.data);
    end
    if (cyc > 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // stop, then the slave must be idle
  task automatic stop_idle();
    m.stop_cond();
    repeat (8) @(negedge i_clock);
    `CHK("active after stop", 1'b0, o_active)
  endtask : stop_idle
  // device byte, pointer, data bytes, stop
  task automatic wr_burst(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] d[$], input logic hit);
    logic ack;
    m.start_cond();
    m.send(dev, 8, ack);
    `CHK("address ack", ~hit, ack)
    if (ack === 1'b0) begin
      m.send(ptr, 8, ack);
      `CHK("pointer ack", 1'b0, ack)
      foreach (d[i]) begin
        m.send(d[i], 8, ack);
        `CHK("data ack", 1'b0, ack)
      end
    end
    stop_idle();
  endtask : wr_burst
  task automatic t_burst_write();
    logic [7:0] exp[3];
    exp = '{8'h0e, 8'hd8, 8'he1};
    wr_a = {};
    wr_d = {};
    wr_burst(8'hc0, 8'h03, {8'h0e, 8'hd8, 8'he1}, 1'b1);
    `CHK("store count", 3, wr_a.size())
    for (int i = 0; i < 3; i++) begin
      `CHK("store addr", 8'h03 + 8'(i), wr_a[i])
      `CHK("store data", exp[i], wr_d[i])
    end
    $display("t_burst_write done");
  endtask : t_burst_write
  task automatic t_read();
    logic ack;
    logic [7:0] b;
    logic [7:0] exp[3];
    exp = '{8'h0e, 8'hd8, 8'he1};
    m.start_cond();
    m.send(8'hc0, 8, ack);
    m.send(8'h03, 8, ack);
    m.start_cond();
    m.send(8'hc1, 8, ack);
    `CHK("read address ack", 1'b0, ack)
    for (int i = 0; i < 3; i++) begin
      m.recv(i < 2, b);
      `CHK("read data", exp[i], b)
    end
    stop_idle();
    $display("t_read done");
  endtask : t_read
  task automatic t_addr_sel();
    wr_a = {};
    wr_d = {};
    wr_burst(8'hc2, 8'h00, {8'h11}, 1'b0);
    @(negedge i_clock) i_addr_sel = 1'b1;
    repeat (8) @(negedge i_clock);
    wr_burst(8'hc0, 8'h00, {8'h11}, 1'b0);
    wr_burst(8'hc2, 8'h07, {8'h5a}, 1'b1);
    `CHK("select store count", 1, wr_a.size())
    `CHK("select store addr", 8'h07, wr_a[0])
    `CHK("select store data", 8'h5a, wr_d[0])
    @(negedge i_clock) i_addr_sel = 1'b0;
    repeat (8) @(negedge i_clock);
    $display("t_addr_sel done");
  endtask : t_addr_sel
  task automatic t_abort();
    logic ack;
    logic [7:0] b;
    wr_a = {};
    m.start_cond();
    m.send(8'hc0, 8, ack);
    m.send(8'h06, 8, ack);
    m.send(8'ha5, 5, ack);
    m.start_cond();
    m.send(8'hc1, 8, ack);
    `CHK("ack after abort", 1'b0, ack)
    m.recv(1'b0, b);
    `CHK("untouched register", 8'h00, b)
    stop_idle();
    `CHK("abort store count", 0, wr_a.size())
    $display("t_abort done");
  endtask : t_abort
  // store past the end of the file, then read across it
  task automatic t_past_end();
    logic ack;
    logic [7:0] b;
    wr_a = {};
    wr_d = {};
    wr_burst(8'hc0, 8'h1f, {8'h3c, 8'hc3}, 1'b1);
    `CHK("past end store count", 2, wr_a.size())
    `CHK("past end store addr", 8'h20, wr_a[1])
    m.start_cond();
    m.send(8'hc0, 8, ack);
    m.send(8'h1f, 8, ack);
    m.start_cond();
    m.send(8'hc1, 8, ack);
    m.recv(1'b1, b);
    `CHK("last register", 8'h3c, b)
    m.recv(1'b0, b);
    `CHK("beyond file", 8'h00, b)
    stop_idle();
    $display("t_past_end done");
  endtask : t_past_end
  // reset, then the scenarios
  initial begin
    i_rst = 1'b1;
    i_addr_sel = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clock);
    t_burst_write();
    t_read();
    t_addr_sel();
    t_abort();
    t_past_end();
    end_of_test();
  end
endmodule : tws_slave_tb
